/* File: hw/umi_pkg.sv */
// Purpose: Shared constants and types of the modem and interrupt control block
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   Modem line structs are active high; pins are inverted at the top

package umi_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_DATA  = 8'h00;
  localparam logic [7:0] OFS_IEN   = 8'h04;
  localparam logic [7:0] OFS_IID   = 8'h08;
  localparam logic [7:0] OFS_LSTAT = 8'h0C;
  localparam logic [7:0] OFS_MCTL  = 8'h10;
  localparam logic [7:0] OFS_MSTAT = 8'h14;
  localparam logic [7:0] OFS_DIV   = 8'h18;

  // Values after reset
  localparam logic [3:0]  IEN_RESET   = 4'h0;
  localparam logic [4:0]  MCTL_RESET  = 5'h00;
  localparam logic [15:0] DIV_RESET   = 16'h0036;

  // Interrupt enable bit positions
  localparam int IEN_RDA  = 0;
  localparam int IEN_TXE  = 1;
  localparam int IEN_RLS  = 2;
  localparam int IEN_MS   = 3;

  // Modem control bit positions
  localparam int MCTL_DTR  = 0;
  localparam int MCTL_RTS  = 1;
  localparam int MCTL_OUT1 = 2;
  localparam int MCTL_OUT2 = 3;
  localparam int MCTL_LOOP = 4;

  // Interrupt identification codes
  localparam logic [7:0] IID_NONE = 8'h01;
  localparam logic [7:0] IID_RLS  = 8'h06;
  localparam logic [7:0] IID_RDA  = 8'h04;
  localparam logic [7:0] IID_TXE  = 8'h02;
  localparam logic [7:0] IID_MS   = 8'h00;

  // Oversampling counts: 16 ticks per bit
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_HALF = 4'h7;
  localparam logic [2:0] BIT_LAST  = 3'h7;

  // Modem input lines, active high, ordered as status bits 7..4
  typedef struct packed {
    logic carrier;
    logic ring;
    logic set_ready;
    logic clear_to_send;
  } umi_modem_s;

  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_START = 2'b01,
    SER_DATA  = 2'b10,
    SER_STOP  = 2'b11
  } umi_ser_e;

endpackage

/* File: hw/umi_tx_shift.sv */
// Purpose: Transmit shift register, 8 data bits, one stop bit
// Assumes: tick16 is a one-cycle pulse at 16 times the bit rate
// Notes:   Takes a character on start only while idle

`timescale 1ns/100ps

module umi_tx_shift (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick16,
  input  wire logic       start,
  input  wire logic [7:0] data,
  output logic            txd,
  output logic            busy
);

  umi_pkg::umi_ser_e state;
  logic [3:0]        tcnt;
  logic [2:0]        bidx;
  logic [7:0]        shreg;

  assign busy = (state != umi_pkg::SER_IDLE);

  // Frame sequencer, bit 0 leaves first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= umi_pkg::SER_IDLE;
      tcnt  <= 4'h0;
      bidx  <= 3'h0;
      shreg <= 8'h00;
      txd   <= 1'b1;
    end else begin
      unique case (state)
        umi_pkg::SER_IDLE: begin
          if (start) begin
            shreg <= data;
            tcnt  <= 4'h0;
            bidx  <= 3'h0;
            txd   <= 1'b0;
            state <= umi_pkg::SER_START;
          end
        end
        umi_pkg::SER_START: begin
          if (tick16) begin
            tcnt <= tcnt + 4'h1;
            if (tcnt == umi_pkg::TICK_LAST) begin
              txd   <= shreg[0];
              state <= umi_pkg::SER_DATA;
            end
          end
        end
        umi_pkg::SER_DATA: begin
          if (tick16) begin
            tcnt <= tcnt + 4'h1;
            if (tcnt == umi_pkg::TICK_LAST) begin
              if (bidx == umi_pkg::BIT_LAST) begin
                txd   <= 1'b1;
                state <= umi_pkg::SER_STOP;
              end else begin
                txd   <= shreg[1];
                shreg <= {1'b0, shreg[7:1]};
                bidx  <= bidx + 3'h1;
              end
            end
          end
        end
        umi_pkg::SER_STOP: begin
          if (tick16) begin
            tcnt <= tcnt + 4'h1;
            if (tcnt == umi_pkg::TICK_LAST) begin
              state <= umi_pkg::SER_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule

/* File: hw/umi_rx_shift.sv */
// Purpose: Receive shift register, 8 data bits, one stop bit
// Assumes: tick16 is a one-cycle pulse at 16 times the bit rate
// Notes:   Samples each bit in its middle; a short start glitch is dropped

`timescale 1ns/100ps

module umi_rx_shift (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick16,
  input  wire logic       rxd,
  output logic            valid,
  output logic [7:0]      data,
  output logic            frame_err,
  output logic            brk
);

  umi_pkg::umi_ser_e state;
  logic [3:0]        tcnt;
  logic [2:0]        bidx;
  logic [7:0]        shreg;

  // Frame sequencer, first bit ends in bit 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= umi_pkg::SER_IDLE;
      tcnt      <= 4'h0;
      bidx      <= 3'h0;
      shreg     <= 8'h00;
      valid     <= 1'b0;
      data      <= 8'h00;
      frame_err <= 1'b0;
      brk       <= 1'b0;
    end else begin
      valid <= 1'b0;
      unique case (state)
        umi_pkg::SER_IDLE: begin
          if (tick16 && !rxd) begin
            tcnt  <= 4'h0;
            bidx  <= 3'h0;
            state <= umi_pkg::SER_START;
          end
        end
        umi_pkg::SER_START: begin
          if (tick16) begin
            tcnt <= tcnt + 4'h1;
            if (tcnt == umi_pkg::TICK_HALF) begin
              tcnt  <= 4'h0;
              state <= rxd ? umi_pkg::SER_IDLE : umi_pkg::SER_DATA;
            end
          end
        end
        umi_pkg::SER_DATA: begin
          if (tick16) begin
            tcnt <= tcnt + 4'h1;
            if (tcnt == umi_pkg::TICK_LAST) begin
              shreg <= {rxd, shreg[7:1]};
              bidx  <= bidx + 3'h1;
              if (bidx == umi_pkg::BIT_LAST) begin
                state <= umi_pkg::SER_STOP;
              end
            end
          end
        end
        umi_pkg::SER_STOP: begin
          if (tick16) begin
            tcnt <= tcnt + 4'h1;
            if (tcnt == umi_pkg::TICK_LAST) begin
              valid     <= 1'b1;
              data      <= shreg;
              frame_err <= ~rxd;
              brk       <= ~rxd & (shreg == 8'h00);
              state     <= umi_pkg::SER_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule

/* File: hw/umi_top.sv */
// Purpose: Modem control, modem status, interrupt enable and data registers
// Assumes: APB slave with no wait states, modem pins synchronous to pclk
// Notes:   Modem pins are active low; outside loopback, status bits read their complement
//
// Decided for this implementation: the APB slave port and the register addresses.

`timescale 1ns/100ps

module umi_top (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                serial_in_pin,
  output logic                     serial_out_pin,
  input  wire umi_pkg::umi_modem_s modem_in_n,
  output logic                     dtr_n,
  output logic                     rts_n,
  output logic                     out1_n,
  output logic                     out2_n,
  output logic                     irq_out
);

  // Address match, used by read mux and every side effect
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [3:0]          interrupt_enable;
  logic [4:0]          modem_control;
  logic [15:0]         baud_divisor;
  logic [15:0]         div_cnt;
  logic                tick16;
  logic [7:0]          transmit_holding;
  logic                tx_holding_empty;
  logic                txe_pend;
  logic [7:0]          receive_buffer;
  logic                data_ready;
  logic                overrun;
  logic                framing_err;
  logic                break_int;
  umi_pkg::umi_modem_s modem_now;
  umi_pkg::umi_modem_s modem_eff;
  logic [3:0]          deltas;
  logic [3:0]          delta_ev;
  logic                loop;
  logic                tx_start;
  logic                tx_busy;
  logic                tx_line;
  logic                rx_in;
  logic                rx_valid;
  logic [7:0]          rx_data;
  logic                rx_fe;
  logic                rx_brk;
  logic                setup;
  logic                wr;
  logic                rd;
  logic                rls_p;
  logic                rda_p;
  logic                txe_p;
  logic                ms_p;
  logic [7:0]          iid;
  logic [7:0]          next_rdata;
  logic                mapped;

  // Bus phases
  assign setup = psel & ~penable;
  assign wr    = psel & penable & pready & pwrite;
  assign rd    = psel & penable & pready & ~pwrite;
  assign loop  = modem_control[umi_pkg::MCTL_LOOP];

  // Modem inputs as seen inside, pins or loopback
  always_comb begin
    if (loop) begin
      modem_eff.clear_to_send = modem_control[umi_pkg::MCTL_RTS];
      modem_eff.set_ready     = modem_control[umi_pkg::MCTL_DTR];
      modem_eff.ring          = modem_control[umi_pkg::MCTL_OUT1];
      modem_eff.carrier       = modem_control[umi_pkg::MCTL_OUT2];
    end else begin
      modem_eff = ~modem_in_n;
    end
  end

  // Change events against last sampled state
  assign delta_ev[0] = modem_eff.clear_to_send ^ modem_now.clear_to_send;
  assign delta_ev[1] = modem_eff.set_ready ^ modem_now.set_ready;
  assign delta_ev[2] = modem_now.ring & ~modem_eff.ring;
  assign delta_ev[3] = modem_eff.carrier ^ modem_now.carrier;

  // Pending sources, each gated by its enable
  assign rls_p  = interrupt_enable[umi_pkg::IEN_RLS] & (overrun | framing_err | break_int);
  assign rda_p  = interrupt_enable[umi_pkg::IEN_RDA] & data_ready;
  assign txe_p  = interrupt_enable[umi_pkg::IEN_TXE] & txe_pend;
  assign ms_p   = interrupt_enable[umi_pkg::IEN_MS] & (|deltas);

  // Highest pending source
  always_comb begin
    if (rls_p) begin
      iid = umi_pkg::IID_RLS;
    end else if (rda_p) begin
      iid = umi_pkg::IID_RDA;
    end else if (txe_p) begin
      iid = umi_pkg::IID_TXE;
    end else if (ms_p) begin
      iid = umi_pkg::IID_MS;
    end else begin
      iid = umi_pkg::IID_NONE;
    end
  end

  // Read data selection
  always_comb begin
    next_rdata = 8'h00;
    mapped     = 1'b1;
    if (hit(paddr, umi_pkg::OFS_DATA)) begin
      next_rdata = receive_buffer;
    end else if (hit(paddr, umi_pkg::OFS_IEN)) begin
      next_rdata = {4'h0, interrupt_enable};
    end else if (hit(paddr, umi_pkg::OFS_IID)) begin
      next_rdata = iid;
    end else if (hit(paddr, umi_pkg::OFS_LSTAT)) begin
      next_rdata = {1'b0, tx_holding_empty & ~tx_busy, tx_holding_empty,
                    break_int, framing_err, 1'b0, overrun, data_ready};
    end else if (hit(paddr, umi_pkg::OFS_MCTL)) begin
      next_rdata = {3'h0, modem_control};
    end else if (hit(paddr, umi_pkg::OFS_MSTAT)) begin
      next_rdata = {modem_now, deltas};
    end else if (hit(paddr, umi_pkg::OFS_DIV)) begin
      next_rdata = 8'h00;
      mapped     = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // APB answer, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        if (hit(paddr, umi_pkg::OFS_DIV)) begin
          prdata <= {16'h0000, baud_divisor};
        end else begin
          prdata <= {24'h00_0000, next_rdata};
        end
      end
    end
  end

  // Software control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable <= umi_pkg::IEN_RESET;
      modem_control    <= umi_pkg::MCTL_RESET;
      baud_divisor     <= umi_pkg::DIV_RESET;
    end else if (wr) begin
      if (hit(paddr, umi_pkg::OFS_IEN)) begin
        interrupt_enable <= pwdata[3:0];
      end
      if (hit(paddr, umi_pkg::OFS_MCTL)) begin
        modem_control <= pwdata[4:0];
      end
      if (hit(paddr, umi_pkg::OFS_DIV)) begin
        baud_divisor <= pwdata[15:0];
      end
    end
  end

  // Oversampling tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
      tick16  <= 1'b0;
    end else if ((div_cnt + 16'h0001) >= baud_divisor) begin
      div_cnt <= 16'h0000;
      tick16  <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick16  <= 1'b0;
    end
  end

  // Modem outputs, inverted from control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtr_n  <= 1'b1;
      rts_n  <= 1'b1;
      out1_n <= 1'b1;
      out2_n <= 1'b1;
    end else begin
      dtr_n  <= ~modem_control[umi_pkg::MCTL_DTR];
      rts_n  <= ~modem_control[umi_pkg::MCTL_RTS];
      out1_n <= ~modem_control[umi_pkg::MCTL_OUT1];
      out2_n <= ~modem_control[umi_pkg::MCTL_OUT2];
    end
  end

  // Modem status: sampled lines and sticky change bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_now <= '0;
      deltas    <= 4'h0;
    end else begin
      modem_now <= modem_eff;
      if (wr && hit(paddr, umi_pkg::OFS_MSTAT)) begin
        deltas <= pwdata[3:0] | delta_ev;
      end else if (rd && hit(paddr, umi_pkg::OFS_MSTAT)) begin
        deltas <= delta_ev;
      end else begin
        deltas <= deltas | delta_ev;
      end
    end
  end

  // Transmit holding register and its empty flag
  assign tx_start = ~tx_holding_empty & ~tx_busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_holding <= 8'h00;
      tx_holding_empty <= 1'b1;
      txe_pend         <= 1'b1;
    end else begin
      if (wr && hit(paddr, umi_pkg::OFS_DATA)) begin
        transmit_holding <= pwdata[7:0];
        tx_holding_empty <= 1'b0;
      end else if (tx_start) begin
        tx_holding_empty <= 1'b1;
      end
      if (tx_start) begin
        txe_pend <= 1'b1;
      end else if (wr && hit(paddr, umi_pkg::OFS_DATA)) begin
        txe_pend <= 1'b0;
      end else if (rd && hit(paddr, umi_pkg::OFS_IID) && (iid == umi_pkg::IID_TXE)) begin
        txe_pend <= 1'b0;
      end
    end
  end

  // Receive buffer and line status flags, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_buffer <= 8'h00;
      data_ready     <= 1'b0;
      overrun        <= 1'b0;
      framing_err    <= 1'b0;
      break_int      <= 1'b0;
    end else begin
      if (rx_valid) begin
        receive_buffer <= rx_data;
        data_ready     <= 1'b1;
      end else if (rd && hit(paddr, umi_pkg::OFS_DATA)) begin
        data_ready <= 1'b0;
      end
      if (rx_valid && data_ready && !(rd && hit(paddr, umi_pkg::OFS_DATA))) begin
        overrun <= 1'b1;
      end else if (rd && hit(paddr, umi_pkg::OFS_LSTAT)) begin
        overrun <= 1'b0;
      end
      if (rx_valid && rx_fe) begin
        framing_err <= 1'b1;
      end else if (rd && hit(paddr, umi_pkg::OFS_LSTAT)) begin
        framing_err <= 1'b0;
      end
      if (rx_valid && rx_brk) begin
        break_int <= 1'b1;
      end else if (rd && hit(paddr, umi_pkg::OFS_LSTAT)) begin
        break_int <= 1'b0;
      end
    end
  end

  // Serial pin and interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pin <= 1'b1;
      irq_out        <= 1'b0;
    end else begin
      serial_out_pin <= loop ? 1'b1 : tx_line;
      irq_out        <= rls_p | rda_p | txe_p | ms_p;
    end
  end

  // Receive input, looped from transmitter in diagnostics
  assign rx_in = loop ? tx_line : serial_in_pin;

  umi_tx_shift u_tx (
    .pclk    (pclk),
    .presetn (presetn),
    .tick16  (tick16),
    .start   (tx_start),
    .data    (transmit_holding),
    .txd     (tx_line),
    .busy    (tx_busy)
  );

  umi_rx_shift u_rx (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick16    (tick16),
    .rxd       (rx_in),
    .valid     (rx_valid),
    .data      (rx_data),
    .frame_err (rx_fe),
    .brk       (rx_brk)
  );

endmodule

/* File: tb/umi_top_asserts.sv */
// Purpose: Port assertions of the modem and interrupt control block
// Assumes: Offsets of umi_pkg, one access cycle after each setup
// Notes:   Shadow copies of enable and control follow APB writes
`timescale 1ns/100ps
module umi_top_asserts (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                serial_in_pin,
  input wire logic                serial_out_pin,
  input wire umi_pkg::umi_modem_s modem_in_n,
  input wire logic                dtr_n,
  input wire logic                rts_n,
  input wire logic                out1_n,
  input wire logic                out2_n,
  input wire logic                irq_out
);
  logic [3:0] ien_q;
  logic [4:0] mctl_q;
  logic [2:0] quiet;
  logic [3:0] pin_d1;
  logic [3:0] pin_d2;
  wire        acc = psel && penable && pready;

  // Shadow registers and cycles since the last control write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q  <= 4'h0;
      mctl_q <= 5'h00;
      quiet  <= 3'h0;
    end else if (acc && pwrite && paddr == umi_pkg::OFS_MCTL) begin
      mctl_q <= pwdata[4:0];
      quiet  <= 3'h0;
    end else begin
      if (acc && pwrite && paddr == umi_pkg::OFS_IEN) begin
        ien_q <= pwdata[3:0];
      end
      if (quiet != 3'h7) begin
        quiet <= quiet + 3'h1;
      end
    end
  end

  // Two past samples of the modem pins
  always_ff @(posedge pclk) begin
    pin_d1 <= modem_in_n;
    pin_d2 <= pin_d1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd(logic [7:0] a);
    acc && !pwrite && paddr == a;
  endsequence
  sequence s_mctl_wr;
    acc && pwrite && paddr == umi_pkg::OFS_MCTL;
  endsequence
  sequence s_stat_rd;
    s_rd(umi_pkg::OFS_MSTAT) ##0 quiet >= 3'h3;
  endsequence

  property p_dtr_rts;
    s_mctl_wr |-> ##2 (dtr_n == !$past(pwdata[0], 2) && rts_n == !$past(pwdata[1], 2));
  endproperty
  property p_aux;
    s_mctl_wr |-> ##2 (out1_n == !$past(pwdata[2], 2) && out2_n == !$past(pwdata[3], 2));
  endproperty
  property p_ien_hi;
    s_rd(umi_pkg::OFS_IEN) |-> prdata[31:4] == 28'h0000000;
  endproperty
  property p_mctl_hi;
    s_rd(umi_pkg::OFS_MCTL) |-> prdata[31:5] == 27'h0000000;
  endproperty
  property p_serial_out_pin_mark;
    mctl_q[4] && quiet >= 3'h2 |-> serial_out_pin;
  endproperty
  property p_irq_off;
    ien_q == 4'h0 && $past(ien_q) == 4'h0 |-> !irq_out;
  endproperty
  property p_stat_pins;
    s_stat_rd ##0 (!mctl_q[4] && modem_in_n == pin_d1 && pin_d1 == pin_d2) |-> prdata[7:4] == ~modem_in_n;
  endproperty
  property p_stat_loop;
    s_stat_rd ##0 mctl_q[4] |-> prdata[7:4] == {mctl_q[3], mctl_q[2], mctl_q[0], mctl_q[1]};
  endproperty
  property p_ms_irq;
    s_rd(umi_pkg::OFS_MSTAT) ##0 (prdata[3:0] != 4'h0 && ien_q[3] && $past(ien_q[3])) |-> irq_out;
  endproperty

  a_dtr_rts: assert property (p_dtr_rts) else $error("ready or request output wrong");
  a_aux: assert property (p_aux) else $error("auxiliary output wrong");
  a_ien_hi: assert property (p_ien_hi) else $error("enable upper bits not zero");
  a_mctl_hi: assert property (p_mctl_hi) else $error("control upper bits not zero");
  a_serial_out_pin_mark: assert property (p_serial_out_pin_mark) else $error("serial out not mark in loopback");
  a_irq_off: assert property (p_irq_off) else $error("interrupt with all enables off");
  a_stat_pins: assert property (p_stat_pins) else $error("status lines differ from pins");
  a_stat_loop: assert property (p_stat_loop) else $error("status lines differ from control");
  a_ms_irq: assert property (p_ms_irq) else $error("modem change without interrupt");
endmodule

bind umi_top umi_top_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin), .modem_in_n(modem_in_n), .dtr_n(dtr_n), .rts_n(rts_n),
  .out1_n(out1_n), .out2_n(out2_n), .irq_out(irq_out)
);

/* File: tb/umi_modem_model.sv */
// Purpose: Modem and serial line partner of the control block
// Assumes: Sixteen pclk cycles per bit, divisor set to one
// Notes:   Lines are commanded active high; the serial line idles at mark
`timescale 1ns/100ps
module umi_modem_model (
  input  wire logic           pclk,
  input  wire logic [3:0]     lines,
  output umi_pkg::umi_modem_s modem_in_n,
  output logic                serial_in_pin
);
  initial serial_in_pin = 1'b1;

  // Pins are active low
  assign modem_in_n = ~lines;

  // Start, eight data bits lowest first, then the given stop level
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      serial_in_pin <= f[i];
      repeat (15) @(posedge pclk);
    end
    @(posedge pclk);
    serial_in_pin <= 1'b1;
  endtask
endmodule

/* File: tb/uart_modem_interrupt_control_tb.sv */
// Purpose: Self-checking bench of the modem and interrupt control block
// Assumes: Slave answers in the access cycle after setup; divisor one
// Notes:   Each scenario drives the block and judges the answers
`timescale 1ns/100ps
module uart_modem_interrupt_control_tb;
  logic                pclk = 1'b0;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [7:0]          paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic [31:0]         rd;
  logic                pready;
  logic                pslverr;
  logic                err;
  logic                serial_in_pin;
  logic                serial_out_pin;
  logic                dtr_n;
  logic                rts_n;
  logic                out1_n;
  logic                out2_n;
  logic                irq_out;
  logic [3:0]          lines;
  umi_pkg::umi_modem_s modem_in_n;
  int                  fail_count = 0;
  int                  n_compared = 0;
  int                  cycles = 0;

  // Clock of 10 ns
  always #5 pclk = ~pclk;

  umi_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .modem_in_n(modem_in_n), .dtr_n(dtr_n), .rts_n(rts_n),
    .out1_n(out1_n), .out2_n(out2_n), .irq_out(irq_out)
  );
  umi_modem_model m (.pclk(pclk), .lines(lines), .modem_in_n(modem_in_n), .serial_in_pin(serial_in_pin));

  // Verdict and end of run
  task automatic stop_test;
    $display("mismatches %0d of %0d compares", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Byte and bit comparisons
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  // Waits whole cycles, then lets the edge updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // One APB transfer; answer taken at the edge that samples ready
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk8(rd[7:0], exp);
  endtask
  task automatic set_lines(input logic [3:0] v);
    @(posedge pclk);
    lines <= v;
    tick(4);
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 400 && irq_out !== 1'b1; i++) begin
      tick(1);
    end
  endtask

  // Reset values, read-zero bits, unmapped place
  task automatic t_regs;
    rdchk(umi_pkg::OFS_IEN, 8'h00);
    rdchk(umi_pkg::OFS_MCTL, 8'h00);
    wr(umi_pkg::OFS_IEN, 32'hF0);
    rdchk(umi_pkg::OFS_IEN, 8'h00);
    apb(1'b0, 8'h1C, 32'h0);
    chk1(err, 1'b1);
    chk8(rd[7:0], 8'h00);
    wr(umi_pkg::OFS_DIV, 32'h1);
  endtask

  // Each control bit alone against its inverted output
  task automatic t_ctrl;
    for (int i = 0; i < 4; i++) begin
      wr(umi_pkg::OFS_MCTL, 32'hE0 | (32'h1 << i));
      rdchk(umi_pkg::OFS_MCTL, 8'h01 << i);
      chk8({4'h0, out2_n, out1_n, rts_n, dtr_n}, ~(8'h01 << i) & 8'h0F);
    end
    wr(umi_pkg::OFS_MCTL, 32'h0);
  endtask

  // Change bits, ring trailing edge only, clear on read
  task automatic t_status;
    set_lines(4'hF);
    rdchk(umi_pkg::OFS_MSTAT, 8'hFB);
    rdchk(umi_pkg::OFS_MSTAT, 8'hF0);
    set_lines(4'h0);
    rdchk(umi_pkg::OFS_MSTAT, 8'h0F);
  endtask

  // Modem and holding-empty interrupts, masking, written status bits
  task automatic t_irq;
    wr(umi_pkg::OFS_IEN, 32'h8);
    set_lines(4'h1);
    chk1(irq_out, 1'b1);
    rdchk(umi_pkg::OFS_MSTAT, 8'h11);
    tick(2);
    chk1(irq_out, 1'b0);
    wr(umi_pkg::OFS_IEN, 32'h0);
    set_lines(4'h0);
    chk1(irq_out, 1'b0);
    rdchk(umi_pkg::OFS_MSTAT, 8'h01);
    wr(umi_pkg::OFS_IEN, 32'h8);
    wr(umi_pkg::OFS_MSTAT, 32'h2);
    tick(2);
    chk1(irq_out, 1'b1);
    rdchk(umi_pkg::OFS_MSTAT, 8'h02);
    wr(umi_pkg::OFS_IEN, 32'h2);
    tick(2);
    chk1(irq_out, 1'b1);
  endtask

  // Received data, line error and ranking of pending sources
  task automatic t_rx;
    wr(umi_pkg::OFS_IEN, 32'h1);
    m.send(8'hA3, 1'b1);
    wait_irq;
    chk1(irq_out, 1'b1);
    wr(umi_pkg::OFS_IEN, 32'h3);
    rdchk(umi_pkg::OFS_IID, umi_pkg::IID_RDA);
    rdchk(umi_pkg::OFS_DATA, 8'hA3);
    rdchk(umi_pkg::OFS_IID, umi_pkg::IID_TXE);
    wr(umi_pkg::OFS_IEN, 32'h5);
    m.send(8'h55, 1'b0);
    wait_irq;
    rdchk(umi_pkg::OFS_IID, umi_pkg::IID_RLS);
    apb(1'b0, umi_pkg::OFS_LSTAT, 32'h0);
    chk8(rd[7:0], 8'h69);
    rdchk(umi_pkg::OFS_DATA, 8'h55);
    wr(umi_pkg::OFS_IEN, 32'h0);
  endtask

  // Bit order on the serial output
  task automatic t_tx;
    logic [7:0] b;
    wr(umi_pkg::OFS_DATA, 32'h3C);
    while (serial_out_pin !== 1'b0) begin
      tick(1);
    end
    tick(8);
    for (int i = 0; i < 8; i++) begin
      tick(16);
      b[i] = serial_out_pin;
    end
    chk8(b, 8'h3C);
    tick(16);
    chk1(serial_out_pin, 1'b1);
  endtask

  // Loopback data path, status from control bits, orderly exit
  task automatic t_loop;
    wr(umi_pkg::OFS_IEN, 32'h1);
    wr(umi_pkg::OFS_MCTL, 32'h10);
    wr(umi_pkg::OFS_DATA, 32'h5A);
    wait_irq;
    chk1(serial_out_pin, 1'b1);
    rdchk(umi_pkg::OFS_DATA, 8'h5A);
    set_lines(4'hF);
    wr(umi_pkg::OFS_MCTL, 32'h13);
    rdchk(umi_pkg::OFS_MSTAT, 8'h33);
    wr(umi_pkg::OFS_IEN, 32'h8);
    wr(umi_pkg::OFS_MCTL, 32'h17);
    wr(umi_pkg::OFS_MCTL, 32'h13);
    tick(3);
    chk1(irq_out, 1'b1);
    rdchk(umi_pkg::OFS_MSTAT, 8'h34);
    wr(umi_pkg::OFS_IEN, 32'h0);
    set_lines(4'h0);
    wr(umi_pkg::OFS_MCTL, 32'h10);
    wr(umi_pkg::OFS_MCTL, 32'h0);
    rdchk(umi_pkg::OFS_MSTAT, 8'h03);
  endtask

  // Cuts a hung run short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test;
    end
  end

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    lines   = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_ctrl;
    t_status;
    t_irq;
    t_rx;
    t_tx;
    t_loop;
    stop_test;
  end
endmodule
